// >>> common/adc_amp_pkg.sv
// Constants shared by the converter control block: register offsets,
// field positions, reset values, channel codes, timing counts and states.
// Assumes an 8-bit register port and a prescaled converter clock enable.
`default_nettype none
package adc_amp_pkg;
  // Register offsets
  localparam logic [7:0] AMP_CTRL_OFS = 8'h75;
  localparam logic [7:0] RES_LO_OFS   = 8'h78;
  localparam logic [7:0] RES_HI_OFS   = 8'h79;
  localparam logic [7:0] CTRL_A_OFS   = 8'h7a;
  localparam logic [7:0] IN_SEL_OFS   = 8'h7c;
  localparam logic [7:0] GAIN_CAL_OFS = 8'h7e;
  localparam logic [7:0] OFFS_CAL_OFS = 8'h7f;
  // Reset values
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [9:0] RES_RESET    = 10'h000;
  // Calibration defaults: gain 0x80 is one, offset is two's complement
  localparam logic [7:0] GAIN_CAL_DEF = 8'h80;
  localparam logic [7:0] OFFS_CAL_DEF = 8'h00;
  // Control register A fields
  localparam int EN_BIT    = 7;
  localparam int START_BIT = 6;
  localparam int ATE_BIT   = 5;
  localparam int FLAG_BIT  = 4;
  localparam int IE_BIT    = 3;
  localparam int PS_LSB    = 0;
  // Input select register fields
  localparam int REF_LSB   = 6;
  localparam int ALIGN_BIT = 5;
  localparam int CHAN_LSB  = 0;
  // Amplifier control register fields
  localparam int AMP_EN_BIT  = 7;
  localparam int AMP_SRC_LSB = 4;
  // Channel codes
  localparam logic [4:0] TEMP_CH = 5'h10;
  localparam logic [4:0] AMP0_CH = 5'h0e;
  localparam logic [4:0] AMP1_CH = 5'h0f;
  // Sync source codes
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  localparam logic [1:0] SRC_STAGE0   = 2'h1;
  localparam logic [1:0] SRC_STAGE1   = 2'h2;
  // Timing in converter clock cycles
  localparam logic [3:0] CONV_CYCLES      = 4'hd;
  localparam logic [3:0] SYNC_CONV_CYCLES = 4'he;
  localparam logic [3:0] CONV_LAST        = CONV_CYCLES - 4'h1;
  localparam logic [3:0] SYNC_CONV_LAST   = SYNC_CONV_CYCLES - 4'h1;
  localparam logic [3:0] SAMPLE_LAST      = 4'h1;
  // Amplifier sync clock is the converter clock divided by eight
  localparam logic [2:0] AMP_RISE_CNT = 3'h3;
  localparam int         AMP_HIGH_BIT = 2;
  // Result layout
  localparam logic [5:0] PAD_ZERO = 6'h00;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SYNC    = 2'b01,
    ST_CONVERT = 2'b10,
    ST_HOLDOFF = 2'b11
  } conv_state_t;
endpackage
`default_nettype wire

// >>> logic/adc_result_amp_sync.sv
// Converter control: registers, conversion sequencer, amplifier sync
// clock, result coding and alignment, calibration bytes.
// Assumes the analog core returns offset-binary codes for amplified
// channels and that adc_tick_in is a one-cycle prescaled clock enable.
//
// Functional notes
// - Single-ended result is unsigned ten-bit code
// - Differential result presented in two's complement
// - Result bit nine is sign, one negative
// - Result bytes load when done flag sets
// - Channel 10000 selects and powers temperature sensor
// - Gain byte 0x80 is one; offset signed
// - Amplifier syncs to stage events or clock/8
// - User start takes 13 or 14 cycles
// - Amplifier amplifies once per sync event
// - Start bit write begins amplified conversion
// - Busy amplified conversion locks out other channels
// - Amplifier change in sample aborts, restarts
// - Align bit selects left or right justify
// - Start bit reads one while converting
// - Done flag clears by vector or one-write
// - Auto trigger on amplified channel waits next sync event
`timescale 1ns/1ps
`default_nettype none
module adc_result_amp_sync
  import adc_amp_pkg::*;
#(
  parameter logic [7:0] GAIN_CAL = GAIN_CAL_DEF,
  parameter logic [7:0] OFFS_CAL = OFFS_CAL_DEF
) (
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       sys_rst_in,
  // Register port
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // Converter clock and triggers
  input  wire logic       adc_tick_in,
  input  wire logic       trigger_in,
  input  wire logic [1:0] pstage_event_in,
  input  wire logic       vector_taken_in,
  // Analog core
  input  wire logic [9:0] core_result_in,
  input  wire logic       amp_change_in,
  output logic      [4:0] channel_out,
  output logic      [1:0] ref_select_out,
  output logic            temp_sensor_on_out,
  output logic            converter_on_out,
  output logic      [2:0] prescale_sel_out,
  output logic            sample_hold_out,
  output logic            amp_on_out,
  output logic            amp_sync_clock_out,
  output logic            amp_strobe_out,
  output logic            done_request_out
);

  conv_state_t st_q, st_d;
  logic       en_q, en_d;
  logic       ate_q, ate_d;
  logic       flag_q, flag_d;
  logic       ie_q, ie_d;
  logic [2:0] ps_q, ps_d;
  logic [1:0] ref_q, ref_d;
  logic       align_q, align_d;
  logic [4:0] chan_field_q, chan_field_d;
  logic       amp_en_q, amp_en_d;
  logic [1:0] amp_src_q, amp_src_d;
  logic [9:0] res_q, res_d;
  logic [3:0] cnt_q, cnt_d;
  logic [3:0] last_q, last_d;
  logic [4:0] chan_q, chan_d;
  logic [2:0] div_q, div_d;
  logic       strobe_q, strobe_d;
  logic [7:0] rdata_q, rdata_d;
  logic       wr_ctrl;
  logic       sw_start;
  logic       auto_start;
  logic       sync_ev;
  logic       chan_is_amp;
  logic       field_is_amp;
  logic       in_sample;
  logic [7:0] res_hi;
  logic [7:0] res_lo;

  // Amplified channels carry differential data
  function automatic logic is_amp(input logic [4:0] ch);
    is_amp = (ch == AMP0_CH) || (ch == AMP1_CH);
  endfunction

  // Request decode and sync event source
  always_comb
  begin
    wr_ctrl      = reg_wr_in && (reg_addr_in == CTRL_A_OFS);
    sw_start     = wr_ctrl && reg_wdata_in[START_BIT] && en_q;
    auto_start   = ate_q && trigger_in;
    chan_is_amp  = is_amp(chan_q);
    field_is_amp = is_amp(chan_field_q);
    in_sample    = (st_q == ST_CONVERT) && (cnt_q <= SAMPLE_LAST);
    case (amp_src_q)
      SRC_INTERNAL: sync_ev = adc_tick_in && (div_q == AMP_RISE_CNT);
      SRC_STAGE0:   sync_ev = pstage_event_in[0];
      SRC_STAGE1:   sync_ev = pstage_event_in[1];
      default:      sync_ev = 1'b0;
    endcase
  end

  // Result presentation, live in the align bit
  always_comb
  begin
    if (align_q)
    begin
      res_hi = res_q[9:2];
      res_lo = {res_q[1:0], PAD_ZERO};
    end
    else
    begin
      res_hi = {PAD_ZERO, res_q[9:8]};
      res_lo = res_q[7:0];
    end
  end

  // Register writes and read data
  always_comb
  begin
    ate_d        = ate_q;
    en_d         = en_q;
    ie_d         = ie_q;
    ps_d         = ps_q;
    ref_d        = ref_q;
    align_d      = align_q;
    chan_field_d = chan_field_q;
    amp_en_d     = amp_en_q;
    amp_src_d    = amp_src_q;
    rdata_d      = REG_RESET;
    if (wr_ctrl)
    begin
      en_d  = reg_wdata_in[EN_BIT];
      ate_d = reg_wdata_in[ATE_BIT];
      ie_d  = reg_wdata_in[IE_BIT];
      ps_d  = reg_wdata_in[PS_LSB +: 3];
    end
    else if (reg_wr_in && (reg_addr_in == IN_SEL_OFS))
    begin
      ref_d        = reg_wdata_in[REF_LSB +: 2];
      align_d      = reg_wdata_in[ALIGN_BIT];
      chan_field_d = reg_wdata_in[CHAN_LSB +: 5];
    end
    else if (reg_wr_in && (reg_addr_in == AMP_CTRL_OFS))
    begin
      amp_en_d  = reg_wdata_in[AMP_EN_BIT];
      amp_src_d = reg_wdata_in[AMP_SRC_LSB +: 2];
    end
    if (reg_rd_in)
    begin
      if (reg_addr_in == CTRL_A_OFS)
      begin
        rdata_d[EN_BIT]        = en_q;
        rdata_d[START_BIT]     = (st_q != ST_IDLE);
        rdata_d[ATE_BIT]       = ate_q;
        rdata_d[FLAG_BIT]      = flag_q;
        rdata_d[IE_BIT]        = ie_q;
        rdata_d[PS_LSB +: 3]   = ps_q;
      end
      else if (reg_addr_in == IN_SEL_OFS)
        rdata_d = {ref_q, align_q, chan_field_q};
      else if (reg_addr_in == AMP_CTRL_OFS)
      begin
        rdata_d[AMP_EN_BIT]         = amp_en_q;
        rdata_d[AMP_SRC_LSB +: 2]   = amp_src_q;
      end
      else if (reg_addr_in == RES_LO_OFS)
        rdata_d = res_lo;
      else if (reg_addr_in == RES_HI_OFS)
        rdata_d = res_hi;
      else if (reg_addr_in == GAIN_CAL_OFS)
        rdata_d = GAIN_CAL;
      else if (reg_addr_in == OFFS_CAL_OFS)
        rdata_d = OFFS_CAL;
      else
        rdata_d = REG_RESET;
    end
  end

  // Amplifier sync clock divider and amplification strobe
  always_comb
  begin
    div_d    = adc_tick_in ? div_q + 3'h1 : div_q;
    strobe_d = amp_en_q && sync_ev;
  end

  // Conversion sequencer, result capture and done flag
  always_comb
  begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    last_d = last_q;
    chan_d = chan_q;
    res_d  = res_q;
    flag_d = flag_q;
    if ((wr_ctrl && reg_wdata_in[FLAG_BIT]) || vector_taken_in)
      flag_d = 1'b0;
    case (st_q)
      ST_IDLE:
      begin
        chan_d = chan_field_q;
        cnt_d  = 4'h0;
        if (sw_start)
        begin
          st_d   = ST_CONVERT;
          last_d = (field_is_amp && div_q[AMP_HIGH_BIT]) ? SYNC_CONV_LAST : CONV_LAST;
        end
        else if (auto_start && en_q)
        begin
          last_d = CONV_LAST;
          st_d   = field_is_amp ? ST_SYNC : ST_CONVERT;
        end
      end
      ST_SYNC:
      begin
        // A newer trigger re-arms, so start follows the latest one
        if (sync_ev && !auto_start)
        begin
          st_d = ST_CONVERT;
        end
      end
      ST_CONVERT:
      begin
        // Starts of any channel are not taken here
        if (chan_is_amp && in_sample && amp_change_in)
        begin
          st_d  = ST_HOLDOFF;
          cnt_d = 4'h0;
        end
        else if (adc_tick_in)
        begin
          if (cnt_q == last_q)
          begin
            st_d   = ST_IDLE;
            flag_d = 1'b1;
            if (chan_is_amp)
            begin
              res_d = {~core_result_in[9], core_result_in[8:0]};
            end
            else
            begin
              res_d = core_result_in;
            end
          end
          else
          begin
            cnt_d = cnt_q + 4'h1;
          end
        end
      end
      ST_HOLDOFF:
      begin
        if (!amp_change_in)
        begin
          st_d   = ST_CONVERT;
          last_d = CONV_LAST;
        end
      end
      default:
      begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      st_q         <= ST_IDLE;
      en_q         <= 1'b0;
      ate_q        <= 1'b0;
      flag_q       <= 1'b0;
      ie_q         <= 1'b0;
      ps_q         <= 3'h0;
      ref_q        <= 2'h0;
      align_q      <= 1'b0;
      chan_field_q <= 5'h00;
      amp_en_q     <= 1'b0;
      amp_src_q    <= SRC_INTERNAL;
      res_q        <= RES_RESET;
      cnt_q        <= 4'h0;
      last_q       <= CONV_LAST;
      chan_q       <= 5'h00;
      div_q        <= 3'h0;
      strobe_q     <= 1'b0;
      rdata_q      <= REG_RESET;
    end
    else
    begin
      st_q         <= st_d;
      en_q         <= en_d;
      ate_q        <= ate_d;
      flag_q       <= flag_d;
      ie_q         <= ie_d;
      ps_q         <= ps_d;
      ref_q        <= ref_d;
      align_q      <= align_d;
      chan_field_q <= chan_field_d;
      amp_en_q     <= amp_en_d;
      amp_src_q    <= amp_src_d;
      res_q        <= res_d;
      cnt_q        <= cnt_d;
      last_q       <= last_d;
      chan_q       <= chan_d;
      div_q        <= div_d;
      strobe_q     <= strobe_d;
      rdata_q      <= rdata_d;
    end
  end

  // Outputs
  assign reg_rdata_out      = rdata_q;
  assign channel_out        = chan_q;
  assign ref_select_out     = ref_q;
  assign temp_sensor_on_out = (chan_q == TEMP_CH);
  assign converter_on_out   = en_q;
  assign prescale_sel_out   = ps_q;
  assign sample_hold_out    = in_sample;
  assign amp_on_out         = amp_en_q;
  assign amp_sync_clock_out = div_q[AMP_HIGH_BIT];
  assign amp_strobe_out     = strobe_q;
  assign done_request_out   = flag_q && ie_q;

endmodule
`default_nettype wire

// >>> bench/core_model.sv
// Analog core stand-in: a prescaled tick every four clocks and a code
// built from the routed channel. Assumes one clock shared with the block.
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       sys_rst_in,
  // Block side
  input  wire logic [4:0] channel_in,
  output logic            tick_out,
  output logic      [9:0] code_out
);
  logic [1:0] div_q;
  // Prescaler divides the clock by four
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
      div_q <= 2'h0;
    else
      div_q <= div_q + 2'h1;
  end
  // Code is only good at the tick; inverted otherwise so stale reads show
  assign tick_out = (div_q == 2'h3);
  assign code_out = tick_out ? {channel_in, 5'h0b} : ~{channel_in, 5'h0b};
endmodule
`default_nettype wire

// >>> bench/adc_amp_sva.sv
// Port checker for the converter control block, bound to its top.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module adc_amp_sva
  import adc_amp_pkg::*;
(
  // Clock and reset
  input wire logic       core_clk_in,
  input wire logic       sys_rst_in,
  // Register port
  input wire logic       reg_rd_in,
  input wire logic       reg_wr_in,
  input wire logic [7:0] reg_rdata_out,
  // Converter side
  input wire logic       adc_tick_in,
  input wire logic       amp_change_in,
  input wire logic [4:0] channel_out,
  input wire logic       temp_sensor_on_out,
  input wire logic       sample_hold_out,
  input wire logic       amp_on_out,
  input wire logic       amp_sync_clock_out,
  input wire logic       amp_strobe_out,
  input wire logic       done_request_out
);
  logic [2:0] div_q;
  logic [1:0] sh_q;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // Ticks since the sync clock last moved, ticks inside the sample phase
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      div_q <= 3'h0;
      sh_q  <= 2'h0;
    end
    else
    begin
      div_q <= ($changed(amp_sync_clock_out) ? 3'h0 : div_q) + {2'h0, adc_tick_in};
      sh_q  <= sample_hold_out ? sh_q + {1'b0, adc_tick_in} : 2'h0;
    end
  end
  temp_route_a: assert property (temp_sensor_on_out == (channel_out == TEMP_CH))
    else $error("sensor power wrong");
  sync_div_a: assert property ($changed(amp_sync_clock_out) |-> div_q == 3'h4)
    else $error("sync clock period wrong");
  strobe_on_a: assert property (amp_strobe_out |-> $past(amp_on_out))
    else $error("strobe while amp off");
  chan_hold_a: assert property (sample_hold_out && $past(sample_hold_out) |-> $stable(channel_out))
    else $error("channel moved");
  sample_max_a: assert property (sample_hold_out |-> sh_q < 2'h2)
    else $error("sample phase too long");
  sample_end_a: assert property ($fell(sample_hold_out) |-> sh_q == 2'h2 || $past(amp_change_in))
    else $error("sample phase cut short");
  done_rise_a: assert property ($rose(done_request_out) |-> $past(adc_tick_in) || $past(reg_wr_in))
    else $error("done rose without cause");
  rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data not idle");
endmodule
bind adc_result_amp_sync adc_amp_sva chk (.core_clk_in, .sys_rst_in, .reg_rd_in, .reg_wr_in,
  .reg_rdata_out, .adc_tick_in, .amp_change_in, .channel_out, .temp_sensor_on_out,
  .sample_hold_out, .amp_on_out, .amp_sync_clock_out, .amp_strobe_out, .done_request_out);
`default_nettype wire

// >>> bench/adc_result_amp_sync_tb_top.sv
// Self-checking bench for the converter control block.
// Assumes the core model supplies ticks and channel-based codes.
`timescale 1ns/1ps
`default_nettype none
module adc_result_amp_sync_tb_top;
  import adc_amp_pkg::*;
  logic       clk, tick, temp_on, amp_clk, strobe, done, conv_on;
  logic [2:0] psel;
  logic       rst = 1'b1;
  logic [5:0] ctl = 6'h00;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [9:0] code;
  logic [9:0] tcnt = 10'h000;
  logic [4:0] chan;
  logic [1:0] pev = 2'h0;
  logic [1:0] reference_select_field;
  int         err_count = 0;
  int         tests_run = 0;
  int         cyc = 0;
  // Strobes and pulses: write, read, trigger, vector, amp change
  wire wr = ctl[0];
  wire rd = ctl[1];
  adc_result_amp_sync dut (
    .core_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .adc_tick_in(tick),
    .trigger_in(ctl[2]), .pstage_event_in(pev), .vector_taken_in(ctl[3]),
    .core_result_in(code), .amp_change_in(ctl[4]), .channel_out(chan),
    .ref_select_out(reference_select_field), .temp_sensor_on_out(temp_on), .converter_on_out(conv_on),
    .prescale_sel_out(psel), .sample_hold_out(), .amp_on_out(), .amp_sync_clock_out(amp_clk),
    .amp_strobe_out(strobe), .done_request_out(done));
  core_model core (.core_clk_in(clk), .sys_rst_in(rst), .channel_in(chan),
    .tick_out(tick), .code_out(code));
  // Clock, tick counter and hang guard
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk)
    if (tick === 1'b1) tcnt = tcnt + 10'h001;
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      err_count = err_count + 1;
      close_out();
    end
  end
  task automatic close_out();
    if (err_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [9:0] e, input logic [9:0] g);
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      err_count = err_count + 1;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask
  // Register port cycles
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    ctl[0] <= 1'b1;
    @(posedge clk);
    ctl[0] <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    ctl[1] <= 1'b1;
    @(posedge clk);
    ctl[1] <= 1'b0;
    @(negedge clk);
    chk({2'h0, e}, {2'h0, rdata});
  endtask
  task automatic pulse(input int b);
    @(posedge clk);
    ctl[b] <= 1'b1;
    @(posedge clk);
    ctl[b] <= 1'b0;
  endtask
  task automatic wait_done();
    for (int i = 0; i < 400 && done !== 1'b1; i++) @(negedge clk);
    chk(10'h001, 10'(done));
  endtask
  // Scenarios
  task automatic t_reset();
    rd_chk(CTRL_A_OFS, REG_RESET);
    rd_chk(IN_SEL_OFS, REG_RESET);
    rd_chk(AMP_CTRL_OFS, REG_RESET);
    rd_chk(RES_HI_OFS, REG_RESET);
    wr_reg(GAIN_CAL_OFS, 8'h00);
    rd_chk(GAIN_CAL_OFS, 8'h80);
    rd_chk(OFFS_CAL_OFS, 8'h00);
    rd_chk(8'h00, 8'h00);
  endtask
  task automatic t_single();
    wr_reg(IN_SEL_OFS, 8'h03);
    wr_reg(CTRL_A_OFS, 8'h88);
    wr_reg(CTRL_A_OFS, 8'hc8);
    tcnt = 10'h000;
    rd_chk(CTRL_A_OFS, 8'hc8);
    wait_done();
    chk(10'h00d, tcnt);
    rd_chk(RES_HI_OFS, 8'h00);
    rd_chk(RES_LO_OFS, 8'h6b);
    rd_chk(CTRL_A_OFS, 8'h98);
    wr_reg(IN_SEL_OFS, 8'h23);
    rd_chk(RES_HI_OFS, 8'h1a);
    rd_chk(RES_LO_OFS, 8'hc0);
    wr_reg(CTRL_A_OFS, 8'h98);
    rd_chk(CTRL_A_OFS, 8'h88);
  endtask
  task automatic t_temp();
    wr_reg(IN_SEL_OFS, 8'hd0);
    rd_chk(IN_SEL_OFS, 8'hd0);
    chk(10'h001, 10'(temp_on));
    chk(10'h003, 10'(reference_select_field));
    wr_reg(CTRL_A_OFS, 8'h8d);
    rd_chk(CTRL_A_OFS, 8'h8d);
    chk(10'h005, 10'(psel));
    chk(10'h001, 10'(conv_on));
  endtask
  task automatic t_amp(input logic lvl);
    wr_reg(AMP_CTRL_OFS, 8'h80);
    wr_reg(IN_SEL_OFS, 8'h0e);
    wait (amp_clk === !lvl);
    wait (amp_clk === lvl);
    wr_reg(CTRL_A_OFS, 8'hc8);
    tcnt = 10'h000;
    wr_reg(IN_SEL_OFS, 8'h03);
    wr_reg(CTRL_A_OFS, 8'hc8);
    chk(10'h00e, 10'(chan));
    wait_done();
    chk(10'h00d + 10'(lvl), tcnt);
    rd_chk(RES_HI_OFS, 8'h03);
    rd_chk(RES_LO_OFS, 8'hcb);
    wr_reg(CTRL_A_OFS, 8'h98);
  endtask
  task automatic t_abort();
    wr_reg(IN_SEL_OFS, 8'h0e);
    wr_reg(CTRL_A_OFS, 8'hc8);
    ctl[4] <= 1'b1;
    repeat (20) @(posedge clk);
    chk(10'h000, 10'(done));
    rd_chk(RES_LO_OFS, 8'hcb);
    @(posedge clk);
    ctl[4] <= 1'b0;
    @(posedge clk);
    tcnt = 10'h000;
    wait_done();
    chk(10'h00d, tcnt);
    wr_reg(CTRL_A_OFS, 8'h98);
  endtask
  task automatic t_auto();
    wr_reg(CTRL_A_OFS, 8'ha8);
    wait (amp_clk === 1'b1);
    wait (amp_clk === 1'b0);
    pulse(2);
    wait (amp_clk === 1'b1);
    tcnt = 10'h000;
    wait_done();
    chk(10'h00d, tcnt);
    pulse(3);
    rd_chk(CTRL_A_OFS, 8'ha8);
  endtask
  // Each power-stage source strobes on its own event only
  task automatic t_stage();
    for (int s = 1; s < 3; s++)
    begin
      wr_reg(AMP_CTRL_OFS, 8'h80 | 8'(s << AMP_SRC_LSB));
      for (int k = 0; k < 2; k++)
      begin
        @(posedge clk);
        pev <= 2'(k == 0 ? s : 3 - s);
        @(posedge clk);
        pev <= 2'h0;
        @(negedge clk);
        chk(10'(k == 0), 10'(strobe));
      end
    end
  endtask
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_single();
    t_temp();
    t_amp(1'b0);
    t_amp(1'b1);
    t_abort();
    t_auto();
    t_stage();
    close_out();
  end
endmodule
`default_nettype wire
